// File: design/pio_regs.vh
// Register map, field layout and reset values of the port block.
// Assumes 32-bit AXI4-Lite words; byte address is four times the index.
//
// Summary of operation
// - Nibble port: bits 3..0 bidirectional with pull-ups, bits 7..4 reserved.
// - Nibble port has no single-bit set or clear; whole-byte writes only.
// - Ordinary read of the shared-function port returns sampled pin levels.
// - Read-modify-write access to the shared-function port uses the latch.
// - Bits 7,6 are read/write strobes; bits 5,4 timer 1/0 count inputs.
// - Bits 3,2 are external interrupts 1/0; bits 1,0 serial transmit/receive.
// - Two per-bit mode registers select each port 0 pin output type.
// - Two per-bit mode registers select each port 1 pin output type.
`ifndef PIO_REGS_VH
`define PIO_REGS_VH

// Register indices
`define PIO_IDX_NIBBLE    8'ha5
`define PIO_IDX_SHARED    8'hb0
`define PIO_IDX_P0_MODE_A 8'hb1
`define PIO_IDX_P0_MODE_B 8'hb2
`define PIO_IDX_P1_MODE_A 8'hb3
`define PIO_IDX_P1_MODE_B 8'hb4
`define PIO_IDX_SHARED_RMW 8'hc0
`define PIO_IDX_SHARED_BIT 8'hc1

// Bit-operation register fields
`define PIO_BIT_SEL_MSB   2
`define PIO_BIT_VAL       3

// Reset values
`define PIO_LATCH_RESET   8'hff
`define PIO_MODE_RESET    8'h00
`define PIO_NIBBLE_MASK   8'h0f

// Mode encodings {mode_a, mode_b}
`define PIO_MODE_QUASI    2'h0
`define PIO_MODE_PUSH     2'h1
`define PIO_MODE_INPUT    2'h2
`define PIO_MODE_OPEN     2'h3

// Bus responses
`define PIO_RESP_OKAY     2'h0
`define PIO_RESP_SLVERR   2'h2

`endif

// File: design/pio_port_block.v
// Port block: nibble port, shared-function port, port 0/1 output modes.
// Assumes one 25 MHz clock, AXI4-Lite master, pins resolved outside.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "pio_regs.vh"

module pio_port_block #(
  parameter AW = 12                       // Bus address width
) (
  input  wire          aclk,              // Core clock
  input  wire          aresetn,           // Sync reset, active low
  input  wire [AW-1:0] s_axi_awaddr,      // Write address
  input  wire          s_axi_awvalid,     // Write address valid
  output reg           s_axi_awready,     // Write address ready
  input  wire [31:0]   s_axi_wdata,       // Write data
  input  wire [3:0]    s_axi_wstrb,       // Write strobes
  input  wire          s_axi_wvalid,      // Write data valid
  output reg           s_axi_wready,      // Write data ready
  output reg  [1:0]    s_axi_bresp,       // Write response
  output reg           s_axi_bvalid,      // Write response valid
  input  wire          s_axi_bready,      // Write response ready
  input  wire [AW-1:0] s_axi_araddr,      // Read address
  input  wire          s_axi_arvalid,     // Read address valid
  output reg           s_axi_arready,     // Read address ready
  output reg  [31:0]   s_axi_rdata,       // Read data
  output reg  [1:0]    s_axi_rresp,       // Read response
  output reg           s_axi_rvalid,      // Read data valid
  input  wire          s_axi_rready,      // Read data ready
  input  wire [3:0]    nibble_pin_in,     // Nibble port pin levels
  output reg  [3:0]    nibble_pin_out,    // Nibble port drive value
  output reg  [3:0]    nibble_pin_oe,     // Nibble port drive enable
  output reg  [3:0]    nibble_pullup_en,  // Nibble port pull-up on
  input  wire [7:0]    shared_pin_in,     // Shared port pin levels
  output reg  [7:0]    shared_pin_out,    // Shared port drive value
  output reg  [7:0]    shared_pin_oe,     // Shared port drive enable
  input  wire          xmem_rd_strobe_n,  // Data-memory read strobe
  input  wire          xmem_wr_strobe_n,  // Data-memory write strobe
  input  wire          serial_txd,        // Serial transmit line
  output reg           timer_zero_count_input, // Timer 0 count pin
  output reg           timer_one_count_input,  // Timer 1 count pin
  output reg           ext_interrupt_zero_input_n, // Ext int 0 level
  output reg           ext_interrupt_one_input_n,  // Ext int 1 level
  output reg           serial_rxd,        // Serial receive line
  input  wire [7:0]    port0_data,        // Port 0 latch from core
  input  wire [7:0]    port0_pin_in,      // Port 0 pin levels
  output reg  [7:0]    port0_pin_out,     // Port 0 drive value
  output reg  [7:0]    port0_pin_oe,      // Port 0 drive enable
  output reg  [7:0]    port0_pullup_en,   // Port 0 weak pull-up on
  output reg  [7:0]    port0_pin_level,   // Port 0 sampled levels
  input  wire [7:0]    port1_data,        // Port 1 latch from core
  input  wire [7:0]    port1_pin_in,      // Port 1 pin levels
  output reg  [7:0]    port1_pin_out,     // Port 1 drive value
  output reg  [7:0]    port1_pin_oe,      // Port 1 drive enable
  output reg  [7:0]    port1_pullup_en,   // Port 1 weak pull-up on
  output reg  [7:0]    port1_pin_level    // Port 1 sampled levels
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, change taken when 2nd and 3rd agree

  localparam NP = 28;
  wire [NP-1:0] pins_raw = {port1_pin_in, port0_pin_in,
                            shared_pin_in, nibble_pin_in};
  reg  [NP-1:0] sync1;
  reg  [NP-1:0] sync2;
  reg  [NP-1:0] sync3;
  reg  [NP-1:0] pin_filt;

  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1    <= {NP{1'b1}};
      sync2    <= {NP{1'b1}};
      sync3    <= {NP{1'b1}};
      pin_filt <= {NP{1'b1}};
    end else begin
      sync1    <= pins_raw;
      sync2    <= sync1;
      sync3    <= sync2;
      pin_filt <= (sync2 & sync3) | (pin_filt & (sync2 | sync3));
    end
  end

  wire [3:0] nibble_lvl = pin_filt[3:0];
  wire [7:0] shared_lvl = pin_filt[11:4];
  wire [7:0] p0_lvl     = pin_filt[19:12];
  wire [7:0] p1_lvl     = pin_filt[27:20];

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  reg  [3:0] nibble_latch;
  // Reserved upper nibble dropped from the shared reset value
  localparam [7:0] NIBBLE_RESET = `PIO_LATCH_RESET & `PIO_NIBBLE_MASK;
  reg  [7:0] shared_latch;
  reg  [7:0] p0_mode_a;
  reg  [7:0] p0_mode_b;
  reg  [7:0] p1_mode_a;
  reg  [7:0] p1_mode_b;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write side: address and data taken in either order

  reg           aw_got;
  reg           w_got;
  reg  [AW-1:0] awaddr_q;
  reg  [31:0]   wdata_q;
  reg           wstrb0_q;
  wire          aw_take = s_axi_awvalid & s_axi_awready;
  wire          w_take  = s_axi_wvalid & s_axi_wready;
  wire          wr_fire = aw_got & w_got;
  wire [7:0]    wr_idx  = awaddr_q[9:2];
  wire [7:0]    wbyte   = wdata_q[7:0];
  wire [2:0]    bit_sel = wbyte[`PIO_BIT_SEL_MSB:0];
  reg           next_aw_got;
  reg           next_w_got;
  reg           next_bvalid;
  reg           wr_hit;

  always @* begin
    next_aw_got = (aw_got | aw_take) & ~wr_fire;
    next_w_got  = (w_got | w_take) & ~wr_fire;
    next_bvalid = wr_fire | (s_axi_bvalid & ~s_axi_bready);
  end

  always @* begin
    wr_hit = (awaddr_q[AW-1:10] == {(AW-10){1'b0}}) &&
             (awaddr_q[1:0] == 2'h0);
    if (wr_idx == `PIO_IDX_NIBBLE) begin
    end else if (wr_idx == `PIO_IDX_SHARED) begin
    end else if (wr_idx == `PIO_IDX_P0_MODE_A) begin
    end else if (wr_idx == `PIO_IDX_P0_MODE_B) begin
    end else if (wr_idx == `PIO_IDX_P1_MODE_A) begin
    end else if (wr_idx == `PIO_IDX_P1_MODE_B) begin
    end else if (wr_idx == `PIO_IDX_SHARED_RMW) begin
    end else if (wr_idx == `PIO_IDX_SHARED_BIT) begin
    end else begin
      wr_hit = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      awaddr_q      <= {AW{1'b0}};
      wdata_q       <= 32'h0;
      wstrb0_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PIO_RESP_OKAY;
      nibble_latch  <= NIBBLE_RESET[3:0];
      shared_latch  <= `PIO_LATCH_RESET;
      p0_mode_a     <= `PIO_MODE_RESET;
      p0_mode_b     <= `PIO_MODE_RESET;
      p1_mode_a     <= `PIO_MODE_RESET;
      p1_mode_b     <= `PIO_MODE_RESET;
    end else begin
      aw_got        <= next_aw_got;
      w_got         <= next_w_got;
      s_axi_bvalid  <= next_bvalid;
      s_axi_awready <= ~next_aw_got & ~next_bvalid;
      s_axi_wready  <= ~next_w_got & ~next_bvalid;
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q  <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        s_axi_bresp <= wr_hit ? `PIO_RESP_OKAY : `PIO_RESP_SLVERR;
      end
      // Only byte lane 0 carries register bits
      if (wr_fire && wr_hit && wstrb0_q) begin
        if (wr_idx == `PIO_IDX_NIBBLE) begin
          nibble_latch <= wbyte[3:0];
        end else if (wr_idx == `PIO_IDX_SHARED ||
                     wr_idx == `PIO_IDX_SHARED_RMW) begin
          shared_latch <= wbyte;
        end else if (wr_idx == `PIO_IDX_P0_MODE_A) begin
          p0_mode_a <= wbyte;
        end else if (wr_idx == `PIO_IDX_P0_MODE_B) begin
          p0_mode_b <= wbyte;
        end else if (wr_idx == `PIO_IDX_P1_MODE_A) begin
          p1_mode_a <= wbyte;
        end else if (wr_idx == `PIO_IDX_P1_MODE_B) begin
          p1_mode_b <= wbyte;
        end else if (wr_idx == `PIO_IDX_SHARED_BIT) begin
          // Bit op modifies the latch, never the pin levels
          shared_latch[bit_sel] <= wbyte[`PIO_BIT_VAL];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read side

  wire [7:0] rd_idx = s_axi_araddr[9:2];
  wire       ar_take = s_axi_arvalid & s_axi_arready;
  reg  [7:0] rd_byte;
  reg        rd_hit;
  reg        next_rvalid;

  always @* begin
    rd_byte = 8'h00;
    rd_hit  = (s_axi_araddr[AW-1:10] == {(AW-10){1'b0}}) &&
              (s_axi_araddr[1:0] == 2'h0);
    if (rd_idx == `PIO_IDX_NIBBLE) begin
      rd_byte = {4'h0, nibble_lvl};
    end else if (rd_idx == `PIO_IDX_SHARED) begin
      rd_byte = shared_lvl;
    end else if (rd_idx == `PIO_IDX_SHARED_RMW) begin
      rd_byte = shared_latch;
    end else if (rd_idx == `PIO_IDX_SHARED_BIT) begin
      rd_byte = 8'h00;
    end else if (rd_idx == `PIO_IDX_P0_MODE_A) begin
      rd_byte = p0_mode_a;
    end else if (rd_idx == `PIO_IDX_P0_MODE_B) begin
      rd_byte = p0_mode_b;
    end else if (rd_idx == `PIO_IDX_P1_MODE_A) begin
      rd_byte = p1_mode_a;
    end else if (rd_idx == `PIO_IDX_P1_MODE_B) begin
      rd_byte = p1_mode_b;
    end else begin
      rd_hit = 1'b0;
    end
    next_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `PIO_RESP_OKAY;
    end else begin
      s_axi_rvalid  <= next_rvalid;
      s_axi_arready <= ~next_rvalid;
      if (ar_take) begin
        s_axi_rdata <= {24'h0, rd_hit ? rd_byte : 8'h00};
        s_axi_rresp <= rd_hit ? `PIO_RESP_OKAY : `PIO_RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers

  // Alternate outputs AND into the latch: keep latch high to pass them
  wire [7:0] shared_drive = shared_latch &
    {xmem_rd_strobe_n, xmem_wr_strobe_n, 4'hf, serial_txd, 1'b1};

  reg  [7:0] next_p0_out;
  reg  [7:0] next_p0_oe;
  reg  [7:0] next_p0_pu;
  reg  [7:0] next_p1_out;
  reg  [7:0] next_p1_oe;
  reg  [7:0] next_p1_pu;
  integer    i;

  always @* begin
    next_p0_out = port0_data;
    next_p1_out = port1_data;
    next_p0_oe  = 8'h00;
    next_p1_oe  = 8'h00;
    next_p0_pu  = 8'h00;
    next_p1_pu  = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      case ({p0_mode_a[i], p0_mode_b[i]})
        `PIO_MODE_QUASI: begin
          next_p0_oe[i] = ~port0_data[i];
          next_p0_pu[i] = 1'b1;
        end
        `PIO_MODE_PUSH:  next_p0_oe[i] = 1'b1;
        `PIO_MODE_INPUT: next_p0_oe[i] = 1'b0;
        default:         next_p0_oe[i] = ~port0_data[i];
      endcase
      case ({p1_mode_a[i], p1_mode_b[i]})
        `PIO_MODE_QUASI: begin
          next_p1_oe[i] = ~port1_data[i];
          next_p1_pu[i] = 1'b1;
        end
        `PIO_MODE_PUSH:  next_p1_oe[i] = 1'b1;
        `PIO_MODE_INPUT: next_p1_oe[i] = 1'b0;
        default:         next_p1_oe[i] = ~port1_data[i];
      endcase
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      nibble_pin_out   <= 4'hf;
      nibble_pin_oe    <= 4'h0;
      nibble_pullup_en <= 4'hf;
      shared_pin_out   <= 8'hff;
      shared_pin_oe    <= 8'h00;
      port0_pin_out    <= 8'hff;
      port0_pin_oe     <= 8'h00;
      port0_pullup_en  <= 8'h00;
      port1_pin_out    <= 8'hff;
      port1_pin_oe     <= 8'h00;
      port1_pullup_en  <= 8'h00;
      port0_pin_level  <= 8'hff;
      port1_pin_level  <= 8'hff;
      timer_zero_count_input     <= 1'b1;
      timer_one_count_input      <= 1'b1;
      ext_interrupt_zero_input_n <= 1'b1;
      ext_interrupt_one_input_n  <= 1'b1;
      serial_rxd                 <= 1'b1;
    end else begin
      // Quasi-bidirectional: pull low actively, weak pull-up for high
      nibble_pin_out   <= nibble_latch;
      nibble_pin_oe    <= ~nibble_latch;
      nibble_pullup_en <= 4'hf;
      shared_pin_out   <= shared_drive;
      shared_pin_oe    <= ~shared_drive;
      port0_pin_out    <= next_p0_out;
      port0_pin_oe     <= next_p0_oe;
      port0_pullup_en  <= next_p0_pu;
      port1_pin_out    <= next_p1_out;
      port1_pin_oe     <= next_p1_oe;
      port1_pullup_en  <= next_p1_pu;
      port0_pin_level  <= p0_lvl;
      port1_pin_level  <= p1_lvl;
      timer_one_count_input      <= shared_lvl[5];
      timer_zero_count_input     <= shared_lvl[4];
      ext_interrupt_one_input_n  <= shared_lvl[3];
      ext_interrupt_zero_input_n <= shared_lvl[2];
      serial_rxd                 <= shared_lvl[0];
    end
  end

endmodule // pio_port_block

// File: verification/pio_pad_model.sv
// Board-side pad model: drive, pull-up and outside source per pin.
// Assumes the bench supplies the outside level of released pins.
`timescale 1ns/1ps
module pio_pad_model #(
  parameter W = 8          // Pin count
) (
  input  wire [W-1:0] out, // Drive value
  input  wire [W-1:0] oe,  // Drive enable
  input  wire [W-1:0] pu,  // Pull-up on
  input  wire [W-1:0] ext, // Outside level
  output wire [W-1:0] pin  // Resolved level
);
  // Pull-up wins: outside source taken as weak
  assign pin = (oe & out) | (~oe & (pu | ext));
endmodule // pio_pad_model

// File: verification/pio_port_block_sva.sv
// Checker for the port block: bus answers and pin relations.
// Assumes it is bound to pio_port_block and sees only its ports.
`timescale 1ns/1ps
module pio_port_block_sva (
  input wire        aclk,                       // Clock
  input wire        aresetn,                    // Reset
  input wire        s_axi_awvalid,              // Bus
  input wire        s_axi_awready,              // Bus
  input wire        s_axi_wvalid,               // Bus
  input wire        s_axi_wready,               // Bus
  input wire        s_axi_bvalid,               // Bus
  input wire        s_axi_arvalid,              // Bus
  input wire        s_axi_arready,              // Bus
  input wire        s_axi_rvalid,               // Bus
  input wire [31:0] s_axi_rdata,                // Bus
  input wire [3:0]  nibble_pullup_en,           // Pins
  input wire [7:0]  shared_pin_in,              // Pins
  input wire [7:0]  shared_pin_out,             // Pins
  input wire        xmem_rd_strobe_n,           // Strobe
  input wire        xmem_wr_strobe_n,           // Strobe
  input wire        serial_txd,                 // Serial
  input wire        timer_zero_count_input,     // Alt input
  input wire        timer_one_count_input,      // Alt input
  input wire        ext_interrupt_zero_input_n, // Alt input
  input wire        ext_interrupt_one_input_n,  // Alt input
  input wire        serial_rxd,                 // Alt input
  input wire [7:0]  port0_pin_out,              // Pins
  input wire [7:0]  port0_pin_oe,               // Pins
  input wire [7:0]  port0_pullup_en,            // Pins
  input wire [7:0]  port1_pin_out,              // Pins
  input wire [7:0]  port1_pin_oe,               // Pins
  input wire [7:0]  port1_pullup_en             // Pins
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence resp_after_update;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  // Window covers the sync stages plus the output register
  sequence pins_settled;
    $stable(shared_pin_in) [*8];
  endsequence
  write_resp_a: assert property (both_taken |=> resp_after_update)
    else $error("write response not two edges after request");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one edge after request");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  nibble_pullup_a: assert property (nibble_pullup_en == 4'hf)
    else $error("nibble pull-ups not all on");
  strobe_gate_a: assert property (1'b1 |=> ({shared_pin_out[7:6],
    shared_pin_out[1]} & ~{$past(xmem_rd_strobe_n),
    $past(xmem_wr_strobe_n), $past(serial_txd)}) == 3'h0)
    else $error("active strobe did not pull its pin low");
  alt_input_a: assert property (pins_settled |-> {timer_one_count_input,
    timer_zero_count_input, ext_interrupt_one_input_n,
    ext_interrupt_zero_input_n, serial_rxd} ==
    {shared_pin_in[5:2], shared_pin_in[0]})
    else $error("alternate input does not follow its pin");
  p0_mode_a: assert property ((port0_pin_oe & port0_pullup_en & port0_pin_out) == 8'h00)
    else $error("port 0 pulled-up pin driven high");
  p1_mode_a: assert property ((port1_pin_oe & port1_pullup_en & port1_pin_out) == 8'h00)
    else $error("port 1 pulled-up pin driven high");
endmodule // pio_port_block_sva

// File: verification/tb_pio_port_block.sv
// Testbench for the port block: registers, pin modes, shared port.
// Assumes pad models stand in for the board on every port.
`timescale 1ns/1ps
`include "pio_regs.vh"
module tb_pio_port_block;
  reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  reg         s_axi_arvalid, s_axi_rready, xmem_rd_strobe_n;
  reg         xmem_wr_strobe_n, serial_txd;
  reg  [11:0] s_axi_awaddr, s_axi_araddr, a;
  reg  [31:0] s_axi_wdata, rnd, got;
  reg  [3:0]  s_axi_wstrb, ext_n;
  reg  [7:0]  port0_data, port1_data, ext_s, ext_0, ext_1, v;
  reg  [1:0]  resp;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire        s_axi_rvalid, timer_zero_count_input, timer_one_count_input;
  wire        ext_interrupt_zero_input_n, ext_interrupt_one_input_n;
  wire        serial_rxd;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0]  nibble_pin_in, nibble_pin_out, nibble_pin_oe, nibble_pullup_en;
  wire [7:0]  shared_pin_in, shared_pin_out, shared_pin_oe;
  wire [7:0]  port0_pin_in, port0_pin_out, port0_pin_oe, port0_pullup_en;
  wire [7:0]  port1_pin_in, port1_pin_out, port1_pin_oe, port1_pullup_en;
  wire [7:0]  port0_pin_level, port1_pin_level;
  integer     n_mismatch, checks, i, m;

  pio_port_block i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nibble_pin_in,
    .nibble_pin_out, .nibble_pin_oe, .nibble_pullup_en, .shared_pin_in,
    .shared_pin_out, .shared_pin_oe, .xmem_rd_strobe_n, .xmem_wr_strobe_n,
    .serial_txd, .timer_zero_count_input, .timer_one_count_input,
    .ext_interrupt_zero_input_n, .ext_interrupt_one_input_n, .serial_rxd,
    .port0_data, .port0_pin_in, .port0_pin_out, .port0_pin_oe,
    .port0_pullup_en, .port0_pin_level, .port1_data, .port1_pin_in,
    .port1_pin_out, .port1_pin_oe, .port1_pullup_en, .port1_pin_level);
  pio_pad_model #(.W(4)) i_npad (.out(nibble_pin_out), .oe(nibble_pin_oe),
    .pu(nibble_pullup_en), .ext(ext_n), .pin(nibble_pin_in));
  pio_pad_model i_spad (.out(shared_pin_out), .oe(shared_pin_oe),
    .pu(8'h00), .ext(ext_s), .pin(shared_pin_in));
  pio_pad_model i_pad0 (.out(port0_pin_out), .oe(port0_pin_oe),
    .pu(port0_pullup_en), .ext(ext_0), .pin(port0_pin_in));
  pio_pad_model i_pad1 (.out(port1_pin_out), .oe(port1_pin_oe),
    .pu(port1_pullup_en), .ext(ext_1), .pin(port1_pin_in));

  task bus_wr(input [11:0] ad, input [7:0] d, output [1:0] r);
    begin
      @(posedge aclk);
      s_axi_awaddr <= ad;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
        if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask
  task bus_rd(input [11:0] ad, output [31:0] d, output [1:0] r);
    begin
      @(posedge aclk);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
  task chk(input [33:0] g, input [33:0] e);
    begin
      checks = checks + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task rchk(input [11:0] ad, input [7:0] e);
    begin
      bus_rd(ad, got, resp);
      chk({resp, got}, {`PIO_RESP_OKAY, 24'h0, e});
    end
  endtask
  task wchk(input [11:0] ad, input [7:0] d);
    begin
      bus_wr(ad, d, resp);
      chk(resp, `PIO_RESP_OKAY);
    end
  endtask
  function [7:0] exp_oe(input [1:0] md, input [7:0] d);
    exp_oe = (md == `PIO_MODE_PUSH) ? 8'hff :
             (md == `PIO_MODE_INPUT) ? 8'h00 : ~d;
  endfunction
  // Pad level: pull-up beats the outside source, open-drain only sinks
  function [7:0] exp_lvl(input [1:0] md, input [7:0] d, input [7:0] e);
    exp_lvl = (md == `PIO_MODE_INPUT) ? e :
              (md == `PIO_MODE_OPEN) ? (d & e) : d;
  endfunction
  task report_and_stop;
    begin
      $display("checks=%0d mismatches=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // Whole run needs a few hundred cycles
  initial begin
    #(40 * 20000);
    n_mismatch = n_mismatch + 1;
    report_and_stop;
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, aresetn, s_axi_awaddr, s_axi_araddr} = 26'h0;
    {xmem_rd_strobe_n, xmem_wr_strobe_n, serial_txd} = 3'h7;
    {s_axi_wdata, s_axi_wstrb, ext_n} = {32'h0, 4'hf, 4'h0};
    {ext_s, ext_0, ext_1, port0_data, port1_data} = 40'h0;
    n_mismatch = 0;
    checks = 0;
    rnd = $urandom(32'hc8db);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (a = 12'h2c4; a <= 12'h2d0; a = a + 12'h004)
      rchk(a, `PIO_MODE_RESET);
    rchk(12'h300, `PIO_LATCH_RESET);
    rchk(12'h294, `PIO_NIBBLE_MASK);
    $display("test reset values done");
    for (a = 12'h2c4; a <= 12'h2d0; a = a + 12'h004) begin
      rnd = $urandom;
      wchk(a, rnd[7:0]);
      rchk(a, rnd[7:0]);
    end
    for (m = 0; m < 4; m = m + 1) begin
      rnd = $urandom;
      port0_data <= rnd[7:0];
      port1_data <= rnd[15:8];
      ext_0 <= rnd[23:16];
      ext_1 <= rnd[31:24];
      wchk(12'h2c4, {8{m[1]}});
      wchk(12'h2c8, {8{m[0]}});
      wchk(12'h2cc, {8{m[1]}});
      wchk(12'h2d0, {8{m[0]}});
      // Pin change needs the sync stages and the level register
      repeat (8) @(posedge aclk);
      chk(port0_pin_oe, exp_oe(m[1:0], rnd[7:0]));
      chk(port1_pin_oe, exp_oe(m[1:0], rnd[15:8]));
      chk(port0_pullup_en, (m[1:0] == `PIO_MODE_QUASI) ? 8'hff : 8'h00);
      chk(port1_pullup_en, (m[1:0] == `PIO_MODE_QUASI) ? 8'hff : 8'h00);
      chk(port0_pin_out, rnd[7:0]);
      chk(port1_pin_out, rnd[15:8]);
      chk(port0_pin_level, exp_lvl(m[1:0], rnd[7:0], rnd[23:16]));
      chk(port1_pin_level, exp_lvl(m[1:0], rnd[15:8], rnd[31:24]));
    end
    $display("test output modes done");
    for (i = 0; i < 6; i = i + 1) begin
      rnd = $urandom;
      ext_s <= rnd[15:8];
      wchk(12'h2c0, rnd[7:0]);
      repeat (8) @(posedge aclk);
      rchk(12'h2c0, rnd[7:0] & rnd[15:8]);
      rchk(12'h300, rnd[7:0]);
      v = rnd[7:0];
      v[rnd[18:16]] = rnd[19];
      wchk(12'h304, {4'h0, rnd[19:16]});
      rchk(12'h300, v);
    end
    $display("test shared port reads done");
    rnd = $urandom;
    wchk(12'h294, rnd[7:0]);
    repeat (8) @(posedge aclk);
    rchk(12'h294, {4'h0, rnd[3:0]});
    wchk(12'h304, {4'h0, ~rnd[0], 3'h0});
    repeat (8) @(posedge aclk);
    rchk(12'h294, {4'h0, rnd[3:0]});
    bus_rd(12'h308, got, resp);
    chk({resp, got}, {`PIO_RESP_SLVERR, 32'h0});
    bus_wr(12'h2c1, 8'h00, resp);
    chk(resp, `PIO_RESP_SLVERR);
    s_axi_wstrb <= 4'he;
    wchk(12'h2c4, 8'h5a);
    s_axi_wstrb <= 4'hf;
    rchk(12'h2c4, 8'hff);
    $display("test nibble port done");
    wchk(12'h2c0, 8'hff);
    for (i = 0; i < 8; i = i + 1) begin
      rnd = $urandom;
      {xmem_rd_strobe_n, xmem_wr_strobe_n, serial_txd} <= rnd[2:0];
      ext_s <= rnd[15:8];
      repeat (9) @(posedge aclk);
      chk({shared_pin_out[7:6], shared_pin_out[1]}, rnd[2:0]);
      chk({timer_one_count_input, timer_zero_count_input,
        ext_interrupt_one_input_n, ext_interrupt_zero_input_n,
        serial_rxd}, {rnd[13:10], rnd[8]});
    end
    $display("test alternate functions done");
    report_and_stop;
  end
endmodule // tb_pio_port_block

bind pio_port_block pio_port_block_sva i_sva (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rdata, .nibble_pullup_en, .shared_pin_in, .shared_pin_out,
  .xmem_rd_strobe_n, .xmem_wr_strobe_n, .serial_txd,
  .timer_zero_count_input, .timer_one_count_input,
  .ext_interrupt_zero_input_n, .ext_interrupt_one_input_n, .serial_rxd,
  .port0_pin_out, .port0_pin_oe, .port0_pullup_en, .port1_pin_out,
  .port1_pin_oe, .port1_pullup_en);
